/* File: include/ssr_pkg.sv */
/*
  Shared constants, register map and helper functions of the synthesizer
  serial write port. Assumes a single reference clock domain for all users.
*/
package ssr_pkg;

  // Frame geometry.
  localparam int SSR_ADDR_W = 4;
  localparam int SSR_DATA_W = 12;
  localparam int SSR_FRAME_W = 16;
  localparam int SSR_NUM_REGS = 10;
  localparam int SSR_ALT_W = 12;

  // Bit counts that classify a transfer when select rises.
  localparam logic [4:0] SSR_FRAME_LEN = 5'h10;
  localparam logic [4:0] SSR_SHORT_MIN = 5'h02;
  localparam logic [4:0] SSR_SHORT_MAX = 5'h0c;
  localparam logic [4:0] SSR_COUNT_SAT = 5'h11;

  // Register addresses.
  localparam logic [3:0] SSR_ADDR_MAIN_INTEGER_DIVIDER = 4'h0;
  localparam logic [3:0] SSR_ADDR_MAIN_FRACTION_UPPER = 4'h1;
  localparam logic [3:0] SSR_ADDR_MAIN_FRACTION_LOWER = 4'h2;
  localparam logic [3:0] SSR_ADDR_AUX_INTEGER_DIVIDER = 4'h3;
  localparam logic [3:0] SSR_ADDR_AUX_FRACTION = 4'h4;
  localparam logic [3:0] SSR_ADDR_REFERENCE_DIVIDE_RATIOS = 4'h5;
  localparam logic [3:0] SSR_ADDR_DETECTOR_GAIN_STEERING = 4'h6;
  localparam logic [3:0] SSR_ADDR_POWERDOWN_OUTPUT_SELECT = 4'h7;
  localparam logic [3:0] SSR_ADDR_MODULATION_SETUP = 4'h8;
  localparam logic [3:0] SSR_ADDR_MODULATION_SAMPLE = 4'h9;
  localparam logic [3:0] SSR_ADDR_LAST = 4'h9;

  // Values after reset.
  localparam logic [11:0] SSR_RESET_DIVIDER = 12'h006;
  localparam logic [11:0] SSR_RESET_OTHER = 12'h000;
  localparam logic [9:0] SSR_RATIO_RESET = 10'h026;
  localparam logic [17:0] SSR_DIVIDEND_RESET = 18'h00000;

  // Field positions.
  localparam int SSR_MODSET_SHIFT_LSB = 0;
  localparam int SSR_MODSET_SHIFT_W = 3;
  localparam int SSR_MODSET_ALT_SRC_BIT = 3;
  localparam int SSR_PDSEL_FRAC18_BIT = 11;
  localparam int SSR_INT_INDEX_W = 9;
  localparam int SSR_FRAC_UPPER_W = 10;
  localparam int SSR_FRAC_LOWER_W = 8;
  localparam int SSR_DIVIDEND_W = 18;
  localparam int SSR_RATIO_W = 10;

  // The divider index is stored as the divide ratio less this offset.
  localparam logic [9:0] SSR_RATIO_OFFSET = 10'h020;

  // Pin synchroniser lanes and their idle levels.
  localparam int SSR_PIN_W = 5;
  localparam int SSR_PIN_SCLK = 0;
  localparam int SSR_PIN_SDATA = 1;
  localparam int SSR_PIN_NCS = 2;
  localparam int SSR_PIN_MODIN = 3;
  localparam int SSR_PIN_VCO = 4;
  localparam logic [4:0] SSR_PIN_IDLE = 5'h04;

  // Sign-extends the low len bits of raw to the full 12 bits.
  function automatic logic [11:0] ssr_sext(input logic [11:0] raw, input logic [3:0] len);
    logic [11:0] mask;
    logic sgn;
    mask = 12'hfff >> (4'hc - len);
    sgn = raw[len - 4'h1];
    ssr_sext = sgn ? (raw | ~mask) : (raw & mask);
  endfunction

  // Value a register takes after reset.
  function automatic logic [11:0] ssr_reset_value(input logic [3:0] addr);
    ssr_reset_value = ((addr == SSR_ADDR_MAIN_INTEGER_DIVIDER) ||
                       (addr == SSR_ADDR_AUX_INTEGER_DIVIDER)) ? SSR_RESET_DIVIDER
                                                                : SSR_RESET_OTHER;
  endfunction

endpackage

/* File: include/ssr_mod_if.sv */
/*
  Link between the serial port and its modulation hand-over unit.
  Assumes both ends run on the reference clock.
*/
`timescale 1ns/1ns
interface ssr_mod_if;
  logic [11:0] sample;
  logic [2:0] shift;
  logic load;
  logic vco_level;

  modport port (output sample, output shift, output load, output vco_level);
  modport unit (input sample, input shift, input load, input vco_level);
endinterface

/* File: rtl/ssr_sync.sv */
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes each lane is an independent level; no word coherence is promised.
*/
`timescale 1ns/1ns
module ssr_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  // The first stage feeds only the second stage, to contain metastability.
  always_comb begin
    next_stage1 = async_in;
    next_sync = stage1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= IDLE;
      sync_out <= IDLE;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync;
    end
  end

endmodule // ssr_sync

/* File: rtl/ssr_mod_unit.sv */
/*
  Modulation hand-over: presents the latest modulation sample, scaled by
  two to the power of the magnitude offset, at the first falling edge of the
  divided main VCO clock after the sample register is written.
  Assumes vco_level is already synchronised to the reference clock.
*/
`timescale 1ns/1ns
module ssr_mod_unit
  import ssr_pkg::*;
#(
  parameter int OUT_W = 19
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  ssr_mod_if.unit mif,
  output logic [OUT_W-1:0] mod_value_out,
  output logic mod_strobe_out
);

  logic vco_prev;
  logic pending;
  logic next_pending;
  logic [OUT_W-1:0] next_value;
  logic next_strobe;
  logic vco_fall;
  logic [OUT_W-1:0] extended;

  // A fresh write that coincides with the edge is consumed by that edge.
  always_comb begin
    vco_fall = vco_prev & ~mif.vco_level;
    extended = {{(OUT_W - SSR_DATA_W){mif.sample[SSR_DATA_W-1]}}, mif.sample};
    next_value = mod_value_out;
    next_strobe = 1'b0;
    next_pending = pending | mif.load;
    if (vco_fall && (pending || mif.load)) begin
      next_value = extended << mif.shift; // RULE8
      next_strobe = 1'b1; // RULE2
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vco_prev <= 1'b0;
      pending <= 1'b0;
      mod_value_out <= '0;
      mod_strobe_out <= 1'b0;
    end else begin
      vco_prev <= mif.vco_level;
      pending <= next_pending;
      mod_value_out <= next_value;
      mod_strobe_out <= next_strobe;
    end
  end

endmodule // ssr_mod_unit

/* File: rtl/ssr_serial_regs.sv */
/*
  Three-wire serial write port of a dual fractional-N synthesizer: addressed
  16-bit register writes and short modulation strobes, with the modulation
  hand-over to the divided main VCO clock.
  Assumes all pins are asynchronous to clk_in, the reference oscillator
  clock, and that the serial clock is well below a quarter of its rate.
  // Function
  // RULE1: Sixteen-cycle select means address plus data write.
  // RULE2: Sample handed over at next divided-VCO falling edge.
  // RULE3: Two to twelve cycle strobe loads a sample.
  // RULE4: Short samples come from main data pin normally.
  // RULE5: Setup bit switches samples to alternate pin.
  // RULE6: All pin inputs resynchronised to reference clock.
  // RULE7: Samples of two to twelve bits accepted.
  // RULE8: Magnitude offset multiplies deviation by two power m.
  // RULE9: Controller keeps dividend plus modulation within range.
  // RULE10: Four-bit address selects one of ten registers.
  // RULE11: Twelve data bits follow the four address bits.
  // RULE12: Registers are write only, no readback.
  // RULE13: Ten-bit mode takes dividend from upper register only.
  // RULE14: Divider value means divide ratio minus thirty-two.
  // RULE15: Serial clock rising edge shifts data while selected.
  // RULE16: Select rising before thirteenth edge loads sample.
  // RULE17: Eighteen-bit mode joins upper ten and lower eight.
  // RULE18: New fraction takes effect on upper register write.
  // RULE19: Commit only when select rises after full frame.
  // RULE20: Short samples sign-extended to twelve bits.
*/
`timescale 1ns/1ns
module ssr_serial_regs
  import ssr_pkg::*;
#(
  parameter int MOD_OUT_W = 19
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic ncs_in,
  input wire logic mod_data_in,
  input wire logic divided_main_vco_clock_in,
  output logic [11:0] main_integer_divider_out,
  output logic [11:0] main_fraction_upper_out,
  output logic [11:0] main_fraction_lower_out,
  output logic [11:0] aux_integer_divider_out,
  output logic [11:0] aux_fraction_out,
  output logic [11:0] reference_divide_ratios_out,
  output logic [11:0] detector_gain_steering_out,
  output logic [11:0] powerdown_output_select_out,
  output logic [11:0] modulation_setup_out,
  output logic [11:0] modulation_sample_out,
  output logic [9:0] main_ratio_out,
  output logic [17:0] main_dividend_out,
  output logic [9:0] aux_ratio_out,
  output logic [9:0] aux_dividend_out,
  output logic [MOD_OUT_W-1:0] mod_value_out,
  output logic mod_strobe_out
);

  // Synchronised pin levels.
  logic [SSR_PIN_W-1:0] pins_sync;
  logic s_sclk;
  logic s_sdata;
  logic s_ncs;
  logic s_modin;

  // Shift state.
  logic sclk_prev;
  logic ncs_prev;
  logic [4:0] bit_count;
  logic [SSR_FRAME_W-1:0] main_shift;
  logic [SSR_ALT_W-1:0] alt_shift;
  logic sample_load;
  logic [4:0] next_bit_count;
  logic [SSR_FRAME_W-1:0] next_main_shift;
  logic [SSR_ALT_W-1:0] next_alt_shift;
  logic next_sample_load;

  // Register file and committed divide ratios.
  logic [11:0] regs [SSR_NUM_REGS];
  logic [11:0] next_regs [SSR_NUM_REGS];
  logic [9:0] next_main_ratio;
  logic [17:0] next_main_dividend;
  logic [9:0] next_aux_ratio;
  logic [9:0] next_aux_dividend;

  // Decode helpers.
  logic sclk_rise;
  logic cs_rise;
  logic [3:0] frame_addr;
  logic [11:0] frame_data;
  logic [11:0] short_raw;
  logic [11:0] upper_val;
  logic frac18;

  ssr_mod_if mif ();

  // Every pin, including the VCO divider clock, crosses here first.
  ssr_sync #(
    .W(SSR_PIN_W),
    .IDLE(SSR_PIN_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in({divided_main_vco_clock_in, mod_data_in, ncs_in, sdata_in, sclk_in}), // RULE6
    .sync_out(pins_sync)
  );

  assign s_sclk = pins_sync[SSR_PIN_SCLK];
  assign s_sdata = pins_sync[SSR_PIN_SDATA];
  assign s_ncs = pins_sync[SSR_PIN_NCS];
  assign s_modin = pins_sync[SSR_PIN_MODIN];

  // Hand-over unit sees the sample register and the magnitude offset.
  assign mif.sample = regs[SSR_ADDR_MODULATION_SAMPLE];
  assign mif.shift = regs[SSR_ADDR_MODULATION_SETUP][SSR_MODSET_SHIFT_LSB +: SSR_MODSET_SHIFT_W];
  assign mif.load = sample_load;
  assign mif.vco_level = pins_sync[SSR_PIN_VCO];

  ssr_mod_unit #(
    .OUT_W(MOD_OUT_W)
  ) u_mod (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .mif(mif),
    .mod_value_out(mod_value_out),
    .mod_strobe_out(mod_strobe_out)
  );

  // Edge detection and frame field views of the shift register.
  always_comb begin
    sclk_rise = s_sclk & ~sclk_prev;
    cs_rise = s_ncs & ~ncs_prev;
    frame_addr = main_shift[SSR_FRAME_W-1 -: SSR_ADDR_W]; // RULE11
    frame_data = main_shift[SSR_DATA_W-1:0];
    upper_val = frame_data;
    frac18 = regs[SSR_ADDR_POWERDOWN_OUTPUT_SELECT][SSR_PDSEL_FRAC18_BIT];
    if (regs[SSR_ADDR_MODULATION_SETUP][SSR_MODSET_ALT_SRC_BIT]) begin
      short_raw = alt_shift; // RULE5
    end else begin
      short_raw = main_shift[SSR_DATA_W-1:0]; // RULE4
    end
  end

  // Shifting and classification of each transfer at the rise of select.
  // Frames longer than sixteen bits keep only their last sixteen bits, since
  // the shifter simply drops what falls off the top.
  always_comb begin
    next_bit_count = bit_count;
    next_main_shift = main_shift;
    next_alt_shift = alt_shift;
    next_sample_load = 1'b0;
    for (int i = 0; i < SSR_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_main_ratio = main_ratio_out;
    next_main_dividend = main_dividend_out;
    next_aux_ratio = aux_ratio_out;
    next_aux_dividend = aux_dividend_out;
    if (cs_rise) begin
      next_bit_count = 5'h00;
      if (bit_count >= SSR_FRAME_LEN) begin // RULE1 RULE19
        if (frame_addr <= SSR_ADDR_LAST) begin // RULE10
          next_regs[frame_addr] = frame_data;
          if (frame_addr == SSR_ADDR_MODULATION_SAMPLE) begin
            next_sample_load = 1'b1;
          end
          if (frame_addr == SSR_ADDR_MAIN_FRACTION_UPPER) begin // RULE18
            next_main_ratio = SSR_RATIO_OFFSET +
              {1'b0, regs[SSR_ADDR_MAIN_INTEGER_DIVIDER][SSR_INT_INDEX_W-1:0]}; // RULE14
            if (frac18) begin
              next_main_dividend = {upper_val[SSR_FRAC_UPPER_W-1:0],
                regs[SSR_ADDR_MAIN_FRACTION_LOWER][SSR_FRAC_LOWER_W-1:0]}; // RULE17
            end else begin
              next_main_dividend = {{(SSR_DIVIDEND_W - SSR_FRAC_UPPER_W){upper_val[9]}},
                upper_val[SSR_FRAC_UPPER_W-1:0]}; // RULE13
            end
          end
          if (frame_addr == SSR_ADDR_AUX_FRACTION) begin
            next_aux_ratio = SSR_RATIO_OFFSET +
              {1'b0, regs[SSR_ADDR_AUX_INTEGER_DIVIDER][SSR_INT_INDEX_W-1:0]}; // RULE14
            next_aux_dividend = frame_data[SSR_RATIO_W-1:0];
          end
        end
      end else if ((bit_count >= SSR_SHORT_MIN) && (bit_count <= SSR_SHORT_MAX)) begin // RULE3 RULE16
        next_regs[SSR_ADDR_MODULATION_SAMPLE] = ssr_sext(short_raw, bit_count[3:0]); // RULE7 RULE20
        next_sample_load = 1'b1;
      end
    end else if (s_ncs) begin
      next_bit_count = 5'h00;
    end else if (sclk_rise) begin
      next_main_shift = {main_shift[SSR_FRAME_W-2:0], s_sdata}; // RULE15
      next_alt_shift = {alt_shift[SSR_ALT_W-2:0], s_modin};
      if (bit_count != SSR_COUNT_SAT) begin
        next_bit_count = bit_count + 5'h01;
      end
    end
  end

  // Registers update on every edge; there is no read path at all.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev <= 1'b0;
      ncs_prev <= 1'b1;
      bit_count <= 5'h00;
      main_shift <= '0;
      alt_shift <= '0;
      sample_load <= 1'b0;
      for (int i = 0; i < SSR_NUM_REGS; i++) begin
        regs[i] <= ssr_reset_value(4'(i));
      end
      main_ratio_out <= SSR_RATIO_RESET;
      main_dividend_out <= SSR_DIVIDEND_RESET;
      aux_ratio_out <= SSR_RATIO_RESET;
      aux_dividend_out <= '0;
    end else begin
      sclk_prev <= s_sclk;
      ncs_prev <= s_ncs;
      bit_count <= next_bit_count;
      main_shift <= next_main_shift;
      alt_shift <= next_alt_shift;
      sample_load <= next_sample_load;
      for (int i = 0; i < SSR_NUM_REGS; i++) begin
        regs[i] <= next_regs[i]; // RULE12
      end
      main_ratio_out <= next_main_ratio;
      main_dividend_out <= next_main_dividend;
      aux_ratio_out <= next_aux_ratio;
      aux_dividend_out <= next_aux_dividend;
    end
  end

  // Register contents leave straight from their flops.
  assign main_integer_divider_out = regs[SSR_ADDR_MAIN_INTEGER_DIVIDER];
  assign main_fraction_upper_out = regs[SSR_ADDR_MAIN_FRACTION_UPPER];
  assign main_fraction_lower_out = regs[SSR_ADDR_MAIN_FRACTION_LOWER];
  assign aux_integer_divider_out = regs[SSR_ADDR_AUX_INTEGER_DIVIDER];
  assign aux_fraction_out = regs[SSR_ADDR_AUX_FRACTION];
  assign reference_divide_ratios_out = regs[SSR_ADDR_REFERENCE_DIVIDE_RATIOS];
  assign detector_gain_steering_out = regs[SSR_ADDR_DETECTOR_GAIN_STEERING];
  assign powerdown_output_select_out = regs[SSR_ADDR_POWERDOWN_OUTPUT_SELECT];
  assign modulation_setup_out = regs[SSR_ADDR_MODULATION_SETUP];
  assign modulation_sample_out = regs[SSR_ADDR_MODULATION_SAMPLE];

  // The controller must keep dividend plus sample in range; no check here. RULE9

endmodule // ssr_serial_regs

/* File: verification/ssr_serial_regs_monitor.sv */
/*
  Port-level checker for the serial write port.
  Assumes it is bound to ssr_serial_regs and sees only its ports.
*/
`timescale 1ns/1ns
module ssr_serial_regs_monitor
  import ssr_pkg::*;
#(
  parameter int MOD_OUT_W = 19
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic ncs_in,
  input wire logic mod_data_in,
  input wire logic divided_main_vco_clock_in,
  input wire logic [11:0] main_integer_divider_out,
  input wire logic [11:0] main_fraction_upper_out,
  input wire logic [11:0] main_fraction_lower_out,
  input wire logic [11:0] aux_integer_divider_out,
  input wire logic [11:0] aux_fraction_out,
  input wire logic [11:0] reference_divide_ratios_out,
  input wire logic [11:0] detector_gain_steering_out,
  input wire logic [11:0] powerdown_output_select_out,
  input wire logic [11:0] modulation_setup_out,
  input wire logic [11:0] modulation_sample_out,
  input wire logic [9:0] main_ratio_out,
  input wire logic [17:0] main_dividend_out,
  input wire logic [9:0] aux_ratio_out,
  input wire logic [9:0] aux_dividend_out,
  input wire logic [MOD_OUT_W-1:0] mod_value_out,
  input wire logic mod_strobe_out
);
  // All register outputs side by side, so one check covers every commit.
  logic [119:0] regs_all;
  assign regs_all = {main_integer_divider_out, main_fraction_upper_out, main_fraction_lower_out,
    aux_integer_divider_out, aux_fraction_out, reference_divide_ratios_out,
    detector_gain_steering_out, powerdown_output_select_out, modulation_setup_out,
    modulation_sample_out};

  // Everything here lives on the reference clock.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_strobe_single: assert property (mod_strobe_out |=> !mod_strobe_out)
    else $error("modulation strobe longer than one cycle");
  chk_value_with_strobe: assert property ($changed(mod_value_out) |-> mod_strobe_out)
    else $error("modulation value moved without strobe");
  chk_strobe_after_fall: assert property (mod_strobe_out |->
    !$past(divided_main_vco_clock_in) && $past(divided_main_vco_clock_in, 7))
    else $error("strobe not tied to a divided clock fall");
  chk_commit_after_rise: assert property ($changed(regs_all) |->
    $past(ncs_in) && !$past(ncs_in, 6))
    else $error("register changed away from a select rise");
  chk_main_ratio_value: assert property ($changed(main_ratio_out) |->
    main_ratio_out == {1'b0, main_integer_divider_out[8:0]} + SSR_RATIO_OFFSET)
    else $error("main ratio is not index plus offset");
  chk_ratio_waits: assert property ($changed(main_integer_divider_out) |->
    $stable(main_ratio_out))
    else $error("main ratio moved on divider write");
  chk_aux_ratio_value: assert property ($changed(aux_ratio_out) |->
    aux_ratio_out == {1'b0, aux_integer_divider_out[8:0]} + SSR_RATIO_OFFSET)
    else $error("aux ratio is not index plus offset");
  chk_dividend_form: assert property ($changed(main_dividend_out) |->
    main_dividend_out == (powerdown_output_select_out[SSR_PDSEL_FRAC18_BIT] ?
    {main_fraction_upper_out[9:0], main_fraction_lower_out[7:0]} :
    {{8{main_fraction_upper_out[9]}}, main_fraction_upper_out[9:0]}))
    else $error("main dividend assembled wrongly");
  chk_shift_low_zero: assert property (mod_strobe_out |->
    (mod_value_out & ~({MOD_OUT_W{1'b1}} << modulation_setup_out[2:0])) == '0)
    else $error("modulation value not shifted by offset");

  cover property (mod_strobe_out);
  cover property ($changed(main_dividend_out));
  cover property ($changed(aux_ratio_out));
endmodule // ssr_serial_regs_monitor

bind ssr_serial_regs ssr_serial_regs_monitor #(.MOD_OUT_W(MOD_OUT_W)) mon_inst (.*);

/* File: verification/ssr_host_model.sv */
/*
  Behavioural serial controller driving select, serial clock and both data pins.
  Assumes send is called just after a rising edge of clk_in.
*/
`timescale 1ns/1ns
module ssr_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic ncs_out,
  output logic mod_data_out
);
  // Idle pins: select high, serial clock parked low.
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    ncs_out = 1'b1;
    mod_data_out = 1'b0;
  end

  // Sends n bits MSB first; half sets the pace, so slow hosts are modelled too.
  task automatic send(input int n, input logic [15:0] v, input logic alt, input int half);
    ncs_out <= 1'b0;
    repeat (half) @(posedge clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      sdata_out <= alt ? ~v[i] : v[i];
      mod_data_out <= alt ? v[i] : ~v[i];
      repeat (half) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (half) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (half) @(posedge clk_in);
    ncs_out <= 1'b1;
    // Released lines flip, so a stale bit can never pass for a live one.
    sdata_out <= ~sdata_out;
    mod_data_out <= ~mod_data_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // ssr_host_model

/* File: verification/ssr_serial_regs_tb.sv */
/*
  Self-checking bench for the serial write port.
  Assumes the host model drives the pins; the bench makes clock, reset and VCO clock.
*/
`timescale 1ns/1ns
module ssr_serial_regs_tb;
  logic clk_in;
  logic nrst_in;
  // Given at declaration so that the divider process is their only driver.
  logic vco = 1'b0;
  logic [4:0] vcnt = 5'h00;
  // Counts hand-over strobes, so one that ends before the waiter starts is not lost.
  int n_stb = 0;
  logic sclk, sdata, ncs, mdat;
  logic [11:0] r [10];
  logic [9:0] mratio, aratio, adiv;
  logic [17:0] mdiv;
  logic [18:0] mval;
  logic mstb;
  int n_errors;
  int num_checks;

  ssr_serial_regs ssr_serial_regs_inst (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk),
    .sdata_in(sdata), .ncs_in(ncs), .mod_data_in(mdat), .divided_main_vco_clock_in(vco),
    .main_integer_divider_out(r[0]), .main_fraction_upper_out(r[1]),
    .main_fraction_lower_out(r[2]), .aux_integer_divider_out(r[3]), .aux_fraction_out(r[4]),
    .reference_divide_ratios_out(r[5]), .detector_gain_steering_out(r[6]),
    .powerdown_output_select_out(r[7]), .modulation_setup_out(r[8]),
    .modulation_sample_out(r[9]), .main_ratio_out(mratio), .main_dividend_out(mdiv),
    .aux_ratio_out(aratio), .aux_dividend_out(adiv), .mod_value_out(mval),
    .mod_strobe_out(mstb));

  ssr_host_model ssr_host_model_inst (.clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata),
    .ncs_out(ncs), .mod_data_out(mdat));

  // Reference clock, 4 ns period.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Divided VCO clock: 32 reference cycles, so the hand-over wait stays short.
  always @(posedge clk_in) begin
    vcnt <= vcnt + 5'h01;
    vco <= vcnt[4];
  end

  // Strobe tally, read by the hand-over waiter.
  always @(posedge clk_in) begin
    if (mstb === 1'b1) begin
      n_stb <= n_stb + 1;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    ssr_host_model_inst.send(16, {a, d}, 1'b0, 4);
  endtask

  // Waits, bounded, for the hand-over strobe of a pending sample; exactly one is wanted.
  task automatic wait_stb(input int base);
    for (int i = 0; i < 100; i++) begin
      if (n_stb != base) break;
      @(posedge clk_in);
    end
    check(n_stb - base, 1);
  endtask

  task automatic t_reset();
    for (int a = 0; a < 10; a++) check(r[a], (a == 0 || a == 3) ? 12'h006 : 12'h000);
    check(mratio, 10'h026);
    check(aratio, 10'h026);
    check(mdiv, 18'h00000);
    check(adiv, 10'h000);
    check(mval, 19'h00000);
    check(mstb, 1'b0);
    $display("reset values done");
  endtask

  task automatic t_regs();
    for (int a = 0; a < 10; a++) wr(a[3:0], 12'h0a0 + a[11:0]);
    for (int a = 0; a < 10; a++) check(r[a], 12'h0a0 + a[11:0]);
    wr(4'ha, 12'hfff);
    for (int a = 0; a < 10; a++) check(r[a], 12'h0a0 + a[11:0]);
    ssr_host_model_inst.send(13, 16'h1555, 1'b0, 4);
    check(r[9], 12'h0a9);
    ssr_host_model_inst.send(1, 16'h0001, 1'b0, 4);
    check(r[9], 12'h0a9);
    $display("register map done");
  endtask

  task automatic t_ratio();
    wr(4'h7, 12'h800);
    wr(4'h0, 12'h00d);
    check(mratio, 10'h0c0);
    wr(4'h2, 12'h098);
    wr(4'h1, 12'h07d);
    check(mratio, 10'h02d);
    check(mdiv, 18'h07d98);
    wr(4'h7, 12'h000);
    wr(4'h0, 12'h010);
    wr(4'h1, 12'h334);
    check(mratio, 10'h030);
    check(mdiv, 18'h3ff34);
    wr(4'h3, 12'h012);
    wr(4'h4, 12'h155);
    check(aratio, 10'h032);
    check(adiv, 10'h155);
    $display("divide ratios done");
  endtask

  task automatic t_mod();
    int s;
    wr(4'h8, 12'h000);
    s = n_stb;
    ssr_host_model_inst.send(2, 16'h0002, 1'b0, 4);
    wait_stb(s);
    check(mval, 19'h7fffe);
    wr(4'h8, 12'h003);
    s = n_stb;
    ssr_host_model_inst.send(12, 16'h07ff, 1'b0, 8);
    wait_stb(s);
    check(mval, 19'h03ff8);
    wr(4'h8, 12'h009);
    s = n_stb;
    ssr_host_model_inst.send(5, 16'h0013, 1'b1, 4);
    wait_stb(s);
    check(mval, 19'h7ffe6);
    s = n_stb;
    wr(4'h9, 12'h801);
    wait_stb(s);
    check(mval, 19'h7f002);
    $display("modulation samples done");
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    nrst_in = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_regs();
    t_ratio();
    t_mod();
    conclude();
  end

  // About 4000 cycles are needed; this bound only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    conclude();
  end
endmodule // ssr_serial_regs_tb
